/* rtl/sdcar_regs.v */
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sdcar_defs.vh"

module sdcar_regs (
  input wire clk,
  input wire srst,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire cmd_start,
  input wire cmd_sending,
  input wire [1:0] expected_response_format,
  output wire [31:0] argument_value,
  input wire resp_bit_valid,
  input wire resp_bit,
  input wire crc_token_valid,
  input wire [7:0] crc_token,
  input wire read_block_end,
  input wire multi_block_read,
  input wire last_block,
  input wire crc_error,
  output wire dat2_out,
  output wire dat2_oe_n,
  output wire read_wait_active
);
  // Bus side of the register file.
  wire wr_en;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  reg wr_err;
  wire [7:0] rd_addr;
  reg [31:0] rd_data;
  reg rd_err;

  // Register storage.
  reg [31:0] command_argument;
  reg [127:0] resp_words;
  wire [127:0] next_words;
  reg [7:0] crc_token_value;
  reg [7:0] response_first_byte;
  reg read_wait_on_crc_error;
  reg read_wait_request;
  wire auto_request;
  wire wr_arg;
  wire wr_tok;
  wire wr_first;
  wire wr_rwc;

  // Response capture state.
  reg [135:0] resp_shift;
  reg [7:0] resp_count;
  reg [1:0] resp_fmt;
  reg resp_armed;
  reg resp_done;
  wire [7:0] resp_len;
  wire resp_long;
  wire [7:0] next_first;

  // Bus front end: it hands at most one decoded write and one read a
  // cycle to the register file below.
  sdcar_axil u_axil (
    .clk(clk),
    .srst(srst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Read wait runs in its own small machine that sees only the request
  // bit and the end-of-block strobe, which keeps the register side simple.
  sdcar_read_wait u_read_wait (
    .clk(clk),
    .srst(srst),
    .request(read_wait_request),
    .block_end(read_block_end),
    .active(read_wait_active),
    .dat2_out(dat2_out),
    .dat2_oe_n(dat2_oe_n)
  );

  assign wr_arg = wr_en && (wr_addr == `SDCAR_OFF_ARG);
  assign wr_tok = wr_en && (wr_addr == `SDCAR_OFF_CRCTOK);
  assign wr_first = wr_en && (wr_addr == `SDCAR_OFF_FIRST);
  assign wr_rwc = wr_en && (wr_addr == `SDCAR_OFF_RWCTL);

  // The shift path reads the live register, so the value survives the
  // send and software only has to reload it when the argument changes.
  assign argument_value = command_argument;

  // Argument writes are dropped while a command shifts out, which keeps
  // the frame on the wire consistent with what was loaded beforehand.
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_arg_byte
      always @(posedge clk) begin
        if (srst) begin
          command_argument[8*b +: 8] <= `SDCAR_RST_BYTE;
        end else if (wr_arg && wr_strb[b] && !cmd_sending) begin
          command_argument[8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  endgenerate

  // Response capture: armed by the command launch, length by format.
  assign resp_long = (resp_fmt == `SDCAR_FMT_LONG);
  assign resp_len = resp_long ? `SDCAR_LEN_LONG : `SDCAR_LEN_SHORT;

  always @(posedge clk) begin
    if (srst) begin
      resp_shift <= 136'h0;
      resp_count <= 8'h00;
      resp_fmt <= `SDCAR_FMT_NONE;
      resp_armed <= 1'b0;
      resp_done <= 1'b0;
    end else begin
      resp_done <= 1'b0;
      if (cmd_start) begin
        resp_fmt <= expected_response_format;
        resp_count <= 8'h00;
        resp_armed <= (expected_response_format != `SDCAR_FMT_NONE);
      end else if (resp_armed && resp_bit_valid) begin
        resp_shift <= {resp_shift[134:0], resp_bit};
        resp_count <= resp_count + 8'h01;
        if (resp_count == resp_len - 8'h01) begin
          resp_armed <= 1'b0;
          resp_done <= 1'b1;
        end
      end
    end
  end

  // Next contents of the eight response words; words a short response
  // does not reach keep what they held.
  // Word five takes the last byte high and leaves its low byte zero.
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_word
      if (i == 7) begin : g_top
        assign next_words[16*i +: 16] = resp_long ?
          resp_shift[16*i +: 16] : resp_shift[39:24];
      end else if (i == 6) begin : g_mid
        assign next_words[16*i +: 16] = resp_long ?
          resp_shift[16*i +: 16] : resp_shift[23:8];
      end else if (i == 5) begin : g_low
        assign next_words[16*i +: 16] = resp_long ?
          resp_shift[16*i +: 16] : {resp_shift[7:0], 8'h00};
      end else begin : g_rest
        assign next_words[16*i +: 16] = resp_long ?
          resp_shift[16*i +: 16] : resp_words[16*i +: 16];
      end
    end
  endgenerate

  // The first byte always comes from the top of the captured frame.
  assign next_first = resp_long ? resp_shift[135:128] : resp_shift[47:40];

  // Words are replaced whether or not software read the last response.
  always @(posedge clk) begin
    if (srst) begin
      resp_words <= 128'h0;
    end else if (resp_done) begin
      resp_words <= next_words;
    end
  end

  // Hardware capture takes priority over a software write in one cycle.
  always @(posedge clk) begin
    if (srst) begin
      response_first_byte <= `SDCAR_RST_BYTE;
    end else if (resp_done) begin
      response_first_byte <= next_first;
    end else if (wr_first && wr_strb[0]) begin
      response_first_byte <= wr_data[7:0];
    end
  end

  // The card's token wins over a software write in the same cycle, since
  // it is the value that software is waiting to read.
  always @(posedge clk) begin
    if (srst) begin
      crc_token_value <= `SDCAR_RST_BYTE;
    end else if (crc_token_valid) begin
      crc_token_value <= crc_token;
    end else if (wr_tok && wr_strb[0]) begin
      crc_token_value <= wr_data[7:0];
    end
  end

  // An automatic request wins over a software clear in the same cycle.
  // Ending a wait needs only the request bit; the enable may stay set.
  assign auto_request = read_wait_on_crc_error && crc_error &&
    multi_block_read && !last_block;

  always @(posedge clk) begin
    if (srst) begin
      read_wait_on_crc_error <= 1'b0;
      read_wait_request <= 1'b0;
    end else begin
      if (wr_rwc && wr_strb[0]) begin
        read_wait_on_crc_error <= wr_data[`SDCAR_RWC_CRC];
      end
      if (auto_request) begin
        read_wait_request <= 1'b1;
      end else if (wr_rwc && wr_strb[0]) begin
        read_wait_request <= wr_data[`SDCAR_RWC_REQ];
      end
    end
  end

  // Read decode; unmapped offsets answer with an error.
  // Status sits at its own offset, so polling never disturbs control.
  always @* begin
    rd_data = `SDCAR_RST_WORD;
    rd_err = 1'b0;
    case (rd_addr)
      `SDCAR_OFF_ARG: rd_data = command_argument;
      `SDCAR_OFF_RSP01: rd_data = resp_words[31:0];
      `SDCAR_OFF_RSP23: rd_data = resp_words[63:32];
      `SDCAR_OFF_RSP45: rd_data = resp_words[95:64];
      `SDCAR_OFF_RSP67: rd_data = resp_words[127:96];
      `SDCAR_OFF_CRCTOK: rd_data = {24'h0, crc_token_value};
      `SDCAR_OFF_FIRST: rd_data = {24'h0, response_first_byte};
      `SDCAR_OFF_RWCTL: begin
        rd_data[`SDCAR_RWC_CRC] = read_wait_on_crc_error;
        rd_data[`SDCAR_RWC_REQ] = read_wait_request;
      end
      `SDCAR_OFF_RWSTAT: rd_data[`SDCAR_RWS_ACTIVE] = read_wait_active;
      default: rd_err = 1'b1;
    endcase
  end

  // Writes to read-only offsets are accepted and have no effect.
  // Unmapped offsets answer with an error so a stray pointer shows early.
  always @* begin
    case (wr_addr)
      `SDCAR_OFF_ARG,
      `SDCAR_OFF_RSP01,
      `SDCAR_OFF_RSP23,
      `SDCAR_OFF_RSP45,
      `SDCAR_OFF_RSP67,
      `SDCAR_OFF_CRCTOK,
      `SDCAR_OFF_FIRST,
      `SDCAR_OFF_RWCTL,
      `SDCAR_OFF_RWSTAT: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end
endmodule // sdcar_regs

/* rtl/sdcar_defs.vh */
`ifndef SDCAR_DEFS_VH
`define SDCAR_DEFS_VH

// Register byte offsets, decoded on address bits 7:0.
`define SDCAR_OFF_ARG 8'h00
`define SDCAR_OFF_RSP01 8'h04
`define SDCAR_OFF_RSP23 8'h08
`define SDCAR_OFF_RSP45 8'h0c
`define SDCAR_OFF_RSP67 8'h10
`define SDCAR_OFF_CRCTOK 8'h14
`define SDCAR_OFF_FIRST 8'h18
`define SDCAR_OFF_RWCTL 8'h1c
`define SDCAR_OFF_RWSTAT 8'h20

// Field positions.
`define SDCAR_RWC_REQ 0
`define SDCAR_RWC_CRC 1
`define SDCAR_RWS_ACTIVE 2

// Reset values.
`define SDCAR_RST_WORD 32'h0000_0000
`define SDCAR_RST_HALF 16'h0000
`define SDCAR_RST_BYTE 8'h00

// Expected response format codes.
`define SDCAR_FMT_NONE 2'h0
`define SDCAR_FMT_SHORT_CRC 2'h1
`define SDCAR_FMT_LONG 2'h2
`define SDCAR_FMT_SHORT_NOCRC 2'h3

// Response lengths in bits.
`define SDCAR_LEN_SHORT 8'h30
`define SDCAR_LEN_LONG 8'h88

// Read wait starts this many clocks after the read block ends.
`define SDCAR_RW_DELAY 2'h2

// AXI response codes.
`define SDCAR_RESP_OKAY 2'h0
`define SDCAR_RESP_SLVERR 2'h2

`endif

/* rtl/sdcar_axil.v */
`timescale 1ns/1ps
`include "sdcar_defs.vh"

module sdcar_axil (
  input wire clk,
  input wire srst,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire wr_en,
  output reg [7:0] wr_addr,
  output reg [31:0] wr_data,
  output reg [3:0] wr_strb,
  input wire wr_err,
  output wire [7:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_err
);
  reg aw_full;
  reg w_full;

  // Address and data are held separately so either may arrive first.
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign wr_en = aw_full & w_full & !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_addr = s_axi_araddr[7:0];

  always @(posedge clk) begin
    if (srst) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wr_addr <= `SDCAR_RST_BYTE;
      wr_data <= `SDCAR_RST_WORD;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SDCAR_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `SDCAR_RST_WORD;
      s_axi_rresp <= `SDCAR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        wr_addr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? `SDCAR_RESP_SLVERR : `SDCAR_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? `SDCAR_RESP_SLVERR : `SDCAR_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // sdcar_axil

/* rtl/sdcar_read_wait.v */
`timescale 1ns/1ps
`include "sdcar_defs.vh"

module sdcar_read_wait (
  input wire clk,
  input wire srst,
  input wire request,
  input wire block_end,
  output wire active,
  output wire dat2_out,
  output reg dat2_oe_n
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ARMED = 2'h1;
  localparam ST_DELAY = 2'h2;
  localparam ST_HOLD = 2'h3;

  reg [1:0] state;
  reg [1:0] count;

  // The line is only ever pulled low; release is done with the enable.
  assign dat2_out = 1'b0;
  assign active = (state == ST_HOLD);

  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      count <= 2'h0;
      dat2_oe_n <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          if (request) begin
            state <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (!request) begin
            state <= ST_IDLE;
          end else if (block_end) begin
            state <= ST_DELAY;
            count <= 2'h1;
          end
        end
        ST_DELAY: begin
          if (!request) begin
            state <= ST_IDLE;
          end else if (count == `SDCAR_RW_DELAY - 2'h1) begin
            state <= ST_HOLD;
            dat2_oe_n <= 1'b0;
          end else begin
            count <= count + 2'h1;
          end
        end
        ST_HOLD: begin
          if (!request) begin
            state <= ST_IDLE;
            dat2_oe_n <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          dat2_oe_n <= 1'b1;
        end
      endcase
    end
  end
endmodule // sdcar_read_wait

/* verification/sdcar_card.sv */
`timescale 1ns/1ps
module sdcar_card (
  input wire clk,
  input wire go,
  input wire [7:0] len,
  input wire [135:0] frame,
  output reg bit_vld,
  output reg bit_val
);
  reg [135:0] sh;
  reg [7:0] n;
  initial begin
    bit_vld = 1'b0;
    bit_val = 1'b0;
    n = 8'h00;
  end
  // Between frames the line toggles, so a stale bit never reads as data.
  always @(posedge clk) begin
    if (go) begin
      sh <= frame << (8'h88 - len);
      n <= len;
    end else if (n != 8'h00) begin
      bit_vld <= 1'b1;
      bit_val <= sh[135];
      sh <= sh << 1;
      n <= n - 8'h01;
    end else begin
      bit_vld <= 1'b0;
      bit_val <= ~bit_val;
    end
  end
endmodule // sdcar_card

/* verification/sdcar_chk.sv */
`timescale 1ns/1ps
module sdcar_chk (
  input wire clk,
  input wire srst,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire cmd_sending,
  input wire [31:0] argument_value,
  input wire read_block_end,
  input wire dat2_out,
  input wire dat2_oe_n,
  input wire read_wait_active
);
  reg [7:0] rd_a;
  always @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_a <= s_axi_araddr[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_rw_go;
    $rose(read_wait_active);
  endsequence
  sequence s_stat_read;
    $rose(s_axi_rvalid) && rd_a == 8'h20;
  endsequence
  property p_oe_status;
    read_wait_active == !dat2_oe_n;
  endproperty
  a_oe_status: assert property (p_oe_status)
    else $error("status and line drive differ");
  property p_line_low;
    !dat2_oe_n |-> !dat2_out;
  endproperty
  a_line_low: assert property (p_line_low)
    else $error("line driven high during read wait");
  property p_rw_delay;
    s_rw_go |-> $past(read_block_end, 2);
  endproperty
  a_rw_delay: assert property (p_rw_delay)
    else $error("read wait began at the wrong cycle");
  property p_rw_release;
    $fell(read_wait_active) |->
      s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_rw_release: assert property (p_rw_release)
    else $error("read wait ended without a write");
  property p_arg_hold;
    cmd_sending |=> $stable(argument_value);
  endproperty
  a_arg_hold: assert property (p_arg_hold)
    else $error("argument changed while sending");
  property p_arg_reset;
    $fell(srst) |-> argument_value == 32'h0;
  endproperty
  a_arg_reset: assert property (p_arg_reset)
    else $error("argument not zero after reset");
  property p_token_upper;
    s_axi_rvalid && rd_a == 8'h14 |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_token_upper: assert property (p_token_upper)
    else $error("token upper bits not zero");
  property p_first_upper;
    s_axi_rvalid && rd_a == 8'h18 |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_first_upper: assert property (p_first_upper)
    else $error("first byte upper bits not zero");
  property p_stat_bits;
    s_stat_read |-> s_axi_rdata == {29'h0, $past(read_wait_active), 2'h0};
  endproperty
  a_stat_bits: assert property (p_stat_bits)
    else $error("status read wrong");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
endmodule // sdcar_chk

/* verification/test_sd_cmd_arg_resp_readwait.sv */
`timescale 1ns/1ps
module test_sd_cmd_arg_resp_readwait;
  logic clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, go, cmd_start, cmd_sending;
  logic crc_token_valid, read_block_end, multi_block_read, last_block;
  logic crc_error;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, seed, x;
  logic [3:0] s_axi_wstrb;
  logic [1:0] expected_response_format;
  logic [7:0] crc_token, len, fb;
  logic [135:0] frame;
  logic [15:0] w [8];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, resp_bit_valid, resp_bit, dat2_out, dat2_oe_n;
  wire read_wait_active;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, argument_value;
  int error_cnt, check_count, k;
  sdcar_regs u_dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cmd_start, .cmd_sending, .expected_response_format, .argument_value,
    .resp_bit_valid, .resp_bit, .crc_token_valid, .crc_token, .read_block_end,
    .multi_block_read, .last_block, .crc_error, .dat2_out, .dat2_oe_n,
    .read_wait_active);
  sdcar_card u_card (.clk, .go, .len, .frame, .bit_vld(resp_bit_valid),
    .bit_val(resp_bit));
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function void model(input logic [1:0] f);
    if (f == 2'h2) begin
      fb = frame[135:128];
      for (int i = 0; i < 8; i++) w[i] = frame[16*i+:16];
    end else if (f != 2'h0) begin
      fb = frame[47:40];
      w[7] = frame[39:24];
      w[6] = frame[23:8];
      w[5] = {frame[7:0], 8'h00};
    end
  endfunction
  task cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task final_report();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, wd, b, v;
    int n;
    @(posedge clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      // Sampled mid-cycle: equal to what the next rising edge sees.
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      wd = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      v = s_axi_bvalid;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
      if (b) break;
      // Ready comes late on purpose, so the response must be held.
      if (v) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    cmp({30'h0, s_axi_bresp}, {30'h0, er});
    if (n == 50) begin
      error_cnt++;
      $display("unexpected at %0t: write timed out", $time);
      final_report();
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar, r;
    logic [31:0] d;
    logic [1:0] rr;
    int n;
    @(posedge clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) break;
    end
    s_axi_rready <= 1'b0;
    cmp(d, e);
    cmp({30'h0, rr}, {30'h0, er});
    if (n == 50) begin
      error_cnt++;
      $display("unexpected at %0t: read timed out", $time);
      final_report();
    end
  endtask
  task resp(input logic [1:0] f);
    frame = {xs(), xs(), xs(), xs(), 8'h00};
    frame[7:0] = 8'(xs());
    @(posedge clk);
    cmd_start <= 1'b1;
    expected_response_format <= f;
    len <= (f == 2'h2) ? 8'h88 : 8'h30;
    @(posedge clk);
    cmd_start <= 1'b0;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (len + 3) @(posedge clk);
    model(f);
    for (k = 0; k < 4; k++)
      rd(8'(8'h04 + 4 * k), {w[2*k+1], w[2*k]}, 2'h0);
    rd(8'h18, {24'h0, fb}, 2'h0);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h10;
    {s_axi_rready, go, cmd_start, cmd_sending, crc_token_valid} = 5'h0;
    {read_block_end, multi_block_read, last_block, crc_error} = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    expected_response_format = 2'h0;
    {crc_token, len, fb} = 24'h0;
    frame = 136'h0;
    for (int i = 0; i < 8; i++) w[i] = 16'h0;
    seed = 32'd35986;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (k = 0; k < 9; k++)
      rd(8'(4 * k), 32'h0, 2'h0);
    rd(8'h24, 32'h0, 2'h2);
    wr(8'h24, xs(), 2'h2);
    x = xs();
    wr(8'h00, x, 2'h0);
    rd(8'h00, x, 2'h0);
    cmd_sending <= 1'b1;
    wr(8'h00, ~x, 2'h0);
    cmd_sending <= 1'b0;
    rd(8'h00, x, 2'h0);
    cmp(argument_value, x);
    resp(2'h2);
    wr(8'h04, xs(), 2'h0);
    wr(8'h10, xs(), 2'h0);
    resp(2'h1);
    resp(2'h3);
    resp(2'h0);
    @(posedge clk);
    crc_token <= x[7:0];
    crc_token_valid <= 1'b1;
    @(posedge clk);
    crc_token_valid <= 1'b0;
    rd(8'h14, {24'h0, x[7:0]}, 2'h0);
    wr(8'h14, 32'hffff_ffff, 2'h0);
    rd(8'h14, 32'h0000_00ff, 2'h0);
    wr(8'h1c, 32'h1, 2'h0);
    @(posedge clk);
    read_block_end <= 1'b1;
    @(posedge clk);
    read_block_end <= 1'b0;
    @(negedge clk);
    cmp({31'h0, dat2_oe_n}, 32'h1);
    @(negedge clk);
    cmp({31'h0, dat2_oe_n}, 32'h0);
    rd(8'h20, 32'h4, 2'h0);
    wr(8'h1c, 32'h0, 2'h0);
    repeat (3) @(posedge clk);
    rd(8'h20, 32'h0, 2'h0);
    // A CRC error on the last block must not stall the card; one on an earlier block must.
    wr(8'h1c, 32'h2, 2'h0);
    multi_block_read <= 1'b1;
    for (k = 0; k < 2; k++) begin
      last_block <= (k == 0);
      @(posedge clk);
      crc_error <= 1'b1;
      @(posedge clk);
      crc_error <= 1'b0;
      rd(8'h1c, 32'(2 + k), 2'h0);
    end
    @(posedge clk);
    read_block_end <= 1'b1;
    @(posedge clk);
    read_block_end <= 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h20, 32'h4, 2'h0);
    wr(8'h1c, 32'h2, 2'h0);
    repeat (3) @(posedge clk);
    rd(8'h20, 32'h0, 2'h0);
    cmp({31'h0, dat2_oe_n}, 32'h1);
    final_report();
  end
endmodule // test_sd_cmd_arg_resp_readwait
bind sdcar_regs sdcar_chk u_chk (.clk, .srst, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .cmd_sending, .argument_value, .read_block_end, .dat2_out,
  .dat2_oe_n, .read_wait_active);
